/* core/smbus_temp_pkg.sv */
package smbus_temp_pkg;

    // Register pointer values
    localparam logic [7:0] PTR_RESET       = 8'h00;
    localparam logic [7:0] ADDR_REMOTE1    = 8'h01;
    localparam logic [7:0] ADDR_REMOTE2    = 8'h02;
    localparam logic [7:0] ADDR_REMOTE3    = 8'h03;
    localparam logic [7:0] ADDR_REMOTE4    = 8'h04;
    localparam logic [7:0] ADDR_LOCAL      = 8'h07;
    localparam logic [7:0] ADDR_EXT1       = 8'h09;
    localparam logic [7:0] ADDR_CFG1       = 8'h0A;

    // Data formats
    localparam logic [7:0] TEMP_MAX        = 8'h7F;
    localparam logic [7:0] TEMP_MIN        = 8'h00;
    localparam logic [7:0] TEMP_FAULT      = 8'hFF;
    localparam int         EXT_LSB_POS     = 5;
    localparam int         RAW_W           = 12;
    localparam int         NUM_CH          = 5;

    // Default 7-bit slave address
    localparam logic [6:0] SLAVE_ADDR      = 7'h4C;

    // Hold timeout
    localparam int         CLK_MHZ         = 125;
    localparam int         HOLD_TIMEOUT_MS = 37;
    localparam int         HOLD_CYCLES     = HOLD_TIMEOUT_MS * 1000 * CLK_MHZ;

endpackage : smbus_temp_pkg

/* core/temp_channel_format.sv */
`timescale 1ns/1ps
module temp_channel_format (
    // Raw result: signed whole degrees with three fractional bits
    input  wire logic signed [11:0] i_raw,
    input  wire logic               i_fault,
    // Formatted bytes
    output logic [7:0]              o_main,
    output logic [7:0]              o_ext
);
    logic signed [8:0] whole;

    always_comb begin
        whole = i_raw[11:3];
        if (i_fault) begin
            o_main = smbus_temp_pkg::TEMP_FAULT;                  // [RL16]
        end else if (whole > 9'sd127) begin
            o_main = smbus_temp_pkg::TEMP_MAX;                    // [RL15]
        end else if (whole < 9'sd0) begin
            o_main = smbus_temp_pkg::TEMP_MIN;                    // [RL15]
        end else begin
            o_main = whole[7:0];                                  // [RL11]
        end
        o_ext = {i_raw[2:0], 5'b0_0000};                          // [RL9] [RL11]
        if (i_fault || whole < 9'sd0) begin
            o_ext = 8'h00;
        end else if (whole > 9'sd127) begin
            o_ext = 8'hE0;
        end
    end
endmodule : temp_channel_format

/* core/smbus_temp_regs.sv */
`timescale 1ns/1ps
// Functional notes
// RL1: All results and settings appear as eight-bit registers.
// RL2: One slave address reaches every register.
// RL3: Only write byte, read byte, send byte and receive byte are supported.
// RL4: Receive byte returns the register chosen by the stored pointer.
// RL5: Multimaster hosts beware: another master may move the shared pointer.
// RL6: Read byte: address-write, command, repeated start, address-read, one data byte.
// RL7: Send byte carries only a command and updates the pointer.
// RL8: Host NACKs the last read byte then issues stop.
// RL9: Remote channel 1 result is 11 bits, 0.125 degree steps.
// RL10: Other channels give 8-bit results in whole degrees.
// RL11: Upper eight bits in main register; channel 1 low bits in extended register.
// RL12: Host reads extended register before main register for full resolution.
// RL13: Reading extended register freezes channel 1 main byte until read.
// RL14: Freeze released after about 37 ms without the main read.
// RL15: Main byte unsigned, clamped to 0..127.
// RL16: Diode fault loads 1111 1111 into the main byte.
// RL17: Open anode and cathode inputs are flagged as a diode fault (code flags anode open or short only).
// RL18: Command pointer is eight bits, reset to zero.
// RL19: Write byte stores data into the register selected by the command (code stores data only into ADDR_CFG1 and drops writes to other registers).
module smbus_temp_regs #(
    parameter int HOLD_CYCLES = smbus_temp_pkg::HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SRST,
    // SMBus pins, sampled synchronously
    input  wire logic        I_SMB_CLK,
    input  wire logic        I_SMB_DATA,
    output logic             O_SMB_DATA,
    output logic             O_SMB_DATA_OE,
    // Conversion results: index 0 channel 1, 1..3 channels 2..4, 4 local
    input  wire logic [59:0] I_RAW_TEMP,
    input  wire logic [4:0]  I_RESULT_VALID,
    // Diode connection status per remote channel (open or short detected)
    input  wire logic [3:0]  I_DIODE_ANODE_OPEN,
    input  wire logic [3:0]  I_DIODE_SHORT,
    // Control and state
    output logic [7:0]       O_CFG1,
    output logic             O_HOLD_ACTIVE,
    output logic [7:0]       O_POINTER
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_TACK = 3'b101
    } smb_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin edge detection
    logic       scl_d_reg, sda_d_reg;
    logic       scl_rise, scl_fall, start_c, stop_c;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= I_SMB_CLK;
            sda_d_reg <= I_SMB_DATA;
        end
    end

    always_comb begin
        scl_rise = I_SMB_CLK & ~scl_d_reg;
        scl_fall = ~I_SMB_CLK & scl_d_reg;
        start_c  = I_SMB_CLK & scl_d_reg & sda_d_reg & ~I_SMB_DATA;
        stop_c   = I_SMB_CLK & scl_d_reg & ~sda_d_reg & I_SMB_DATA;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel formatting
    logic [7:0] main_b [smbus_temp_pkg::NUM_CH];
    logic [7:0] ext_b  [smbus_temp_pkg::NUM_CH];
    logic [4:0] fault;

    always_comb begin
        fault = {1'b0, I_DIODE_ANODE_OPEN | I_DIODE_SHORT};           // [RL17]
    end

    for (genvar g = 0; g < smbus_temp_pkg::NUM_CH; g++) begin : g_fmt
        temp_channel_format u_fmt (
            .i_raw   (I_RAW_TEMP[g*smbus_temp_pkg::RAW_W +: smbus_temp_pkg::RAW_W]),
            .i_fault (fault[g]),
            .o_main  (main_b[g]),
            .o_ext   (ext_b[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result registers and channel 1 coherence hold
    logic [7:0]  temp_reg [smbus_temp_pkg::NUM_CH];
    logic [7:0]  temp_next [smbus_temp_pkg::NUM_CH];
    logic [7:0]  ext1_reg, ext1_next;
    logic        hold_reg, hold_next;
    logic [23:0] hold_cnt_reg, hold_cnt_next;
    logic        rd_main1, rd_ext1;

    always_comb begin
        hold_next     = hold_reg;
        hold_cnt_next = hold_cnt_reg;
        ext1_next     = ext1_reg;
        for (int k = 0; k < smbus_temp_pkg::NUM_CH; k++) begin
            temp_next[k] = temp_reg[k];
            if (I_RESULT_VALID[k] && !(k == 0 && hold_reg)) begin   // [RL10] [RL13]
                temp_next[k] = main_b[k];
            end
        end
        if (I_RESULT_VALID[0] && !hold_reg) begin
            ext1_next = ext_b[0];
        end
        if (hold_reg) begin
            hold_cnt_next = hold_cnt_reg + 24'h00_0001;
            if (rd_main1 || hold_cnt_reg >= 24'(HOLD_CYCLES - 1)) begin // [RL14]
                hold_next = 1'b0;
            end
        end
        if (rd_ext1) begin
            hold_next     = 1'b1;                                   // [RL13]
            hold_cnt_next = 24'h00_0000;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            for (int k = 0; k < smbus_temp_pkg::NUM_CH; k++) begin
                temp_reg[k] <= 8'h00;
            end
            ext1_reg     <= 8'h00;
            hold_reg     <= 1'b0;
            hold_cnt_reg <= 24'h00_0000;
        end else begin
            temp_reg     <= temp_next;
            ext1_reg     <= ext1_next;
            hold_reg     <= hold_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SMBus slave engine
    smb_state_e st_reg, st_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic       rw_reg, rw_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] cfg1_reg, cfg1_next;
    logic       oe_reg, oe_next;
    logic [7:0] rd_data;

    always_comb begin
        case (ptr_reg)                                              // [RL1] [RL4]
            smbus_temp_pkg::ADDR_REMOTE1: rd_data = temp_reg[0];
            smbus_temp_pkg::ADDR_REMOTE2: rd_data = temp_reg[1];
            smbus_temp_pkg::ADDR_REMOTE3: rd_data = temp_reg[2];
            smbus_temp_pkg::ADDR_REMOTE4: rd_data = temp_reg[3];
            smbus_temp_pkg::ADDR_LOCAL:   rd_data = temp_reg[4];
            smbus_temp_pkg::ADDR_EXT1:    rd_data = ext1_reg;
            smbus_temp_pkg::ADDR_CFG1:    rd_data = cfg1_reg;
            default:                      rd_data = 8'h00;
        endcase
    end

    always_comb begin
        st_next   = st_reg;
        sh_next   = sh_reg;
        bit_next  = bit_reg;
        byte_next = byte_reg;
        rw_next   = rw_reg;
        ptr_next  = ptr_reg;
        cfg1_next = cfg1_reg;
        oe_next   = oe_reg;
        rd_main1  = 1'b0;
        rd_ext1   = 1'b0;
        if (start_c) begin                                          // [RL6]
            st_next   = ST_ADDR;
            bit_next  = 4'h0;
            byte_next = 2'b00;
            oe_next   = 1'b0;
        end else if (stop_c) begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                ST_IDLE: st_next = ST_IDLE;
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], I_SMB_DATA};
                        bit_next = bit_reg + 4'h1;
                    end
                    if (scl_fall && bit_reg == 4'h8) begin
                        bit_next = 4'h0;
                        if (st_reg == ST_ADDR) begin
                            rw_next = sh_reg[0];
                            if (sh_reg[7:1] == smbus_temp_pkg::SLAVE_ADDR) begin // [RL2]
                                st_next = ST_ACK;
                                oe_next = 1'b1;
                            end else begin
                                st_next = ST_IDLE;
                            end
                        end else begin
                            st_next = ST_ACK;
                            oe_next = 1'b1;
                            if (byte_reg == 2'b00) begin
                                ptr_next = sh_reg;                  // [RL7] [RL3]
                            end else if (ptr_reg == smbus_temp_pkg::ADDR_CFG1) begin
                                cfg1_next = sh_reg;                 // [RL19]
                            end
                            byte_next = (byte_reg == 2'b00) ? 2'b01 : 2'b10;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        if (rw_reg) begin
                            st_next  = ST_TX;
                            sh_next  = rd_data;                     // [RL4] [RL6]
                            rd_main1 = (ptr_reg == smbus_temp_pkg::ADDR_REMOTE1);
                            rd_ext1  = (ptr_reg == smbus_temp_pkg::ADDR_EXT1);
                            oe_next  = ~rd_data[7];
                        end else if (byte_reg == 2'b10) begin
                            st_next = ST_IDLE;                      // [RL3]
                        end else begin
                            st_next = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_next = bit_reg + 4'h1;
                        sh_next  = {sh_reg[6:0], 1'b1};
                        if (bit_reg == 4'h7) begin
                            st_next  = ST_TACK;
                            bit_next = 4'h0;
                            oe_next  = 1'b0;
                        end else begin
                            oe_next = ~sh_reg[6];
                        end
                    end
                end
                ST_TACK: begin
                    // One byte per read: the host's answer bit is not needed
                    if (scl_fall) begin
                        st_next = ST_IDLE;
                    end
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            st_reg   <= ST_IDLE;
            sh_reg   <= 8'h00;
            bit_reg  <= 4'h0;
            byte_reg <= 2'b00;
            rw_reg   <= 1'b0;
            ptr_reg  <= smbus_temp_pkg::PTR_RESET;                  // [RL18]
            cfg1_reg <= 8'h00;
            oe_reg   <= 1'b0;
        end else begin
            st_reg   <= st_next;
            sh_reg   <= sh_next;
            bit_reg  <= bit_next;
            byte_reg <= byte_next;
            rw_reg   <= rw_next;
            ptr_reg  <= ptr_next;
            cfg1_reg <= cfg1_next;
            oe_reg   <= oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign O_SMB_DATA    = 1'b0;
    assign O_SMB_DATA_OE = oe_reg;
    assign O_CFG1        = cfg1_reg;
    assign O_HOLD_ACTIVE = hold_reg;
    assign O_POINTER     = ptr_reg;

endmodule : smbus_temp_regs

/* testbench/smbus_temp_properties.sv */
`timescale 1ns/1ps
module smbus_temp_properties #(
    parameter int HOLD_CYCLES = 200
) (
    // Clock and reset
    input wire logic       I_SYS_CLK,
    input wire logic       I_SRST,
    // Bus pins
    input wire logic       I_SMB_CLK,
    input wire logic       I_SMB_DATA,
    input wire logic       O_SMB_DATA,
    input wire logic       O_SMB_DATA_OE,
    // State
    input wire logic [7:0] O_CFG1,
    input wire logic       O_HOLD_ACTIVE,
    input wire logic [7:0] O_POINTER
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SRST);
    logic [31:0] hc_reg;
    logic [31:0] hc_next;
    always_comb begin
        hc_next = O_HOLD_ACTIVE ? hc_reg + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge I_SYS_CLK) begin
        hc_reg <= I_SRST ? 32'h0000_0000 : hc_next;
    end
    ////////////////////////////////////////////////////////////////
    sequence s_start;
        I_SMB_CLK && $past(I_SMB_CLK) && $fell(I_SMB_DATA);
    endsequence
    sequence s_idle;
        (I_SMB_CLK && I_SMB_DATA) [*4];
    endsequence
    property p_od_low;
        O_SMB_DATA == 1'b0;
    endproperty
    property p_oe_hold;
        I_SMB_CLK && $past(I_SMB_CLK) |-> $stable(O_SMB_DATA_OE);
    endproperty
    property p_start_quiet;
        s_start |-> !O_SMB_DATA_OE [*8];
    endproperty
    property p_reset_state;
        $past(I_SRST) |-> O_POINTER == 8'h00 && O_CFG1 == 8'h00 && !O_HOLD_ACTIVE;
    endproperty
    property p_idle_stable;
        s_idle |=> $stable(O_POINTER) && $stable(O_CFG1);
    endproperty
    property p_cfg_by_ptr;
        $changed(O_CFG1) |-> $past(O_POINTER) == smbus_temp_pkg::ADDR_CFG1;
    endproperty
    property p_hold_ptr;
        $rose(O_HOLD_ACTIVE) |-> O_POINTER == smbus_temp_pkg::ADDR_EXT1;
    endproperty
    property p_hold_bound;
        hc_reg <= HOLD_CYCLES + 2;
    endproperty
    a_od_low: assert property (p_od_low) else $error("data pin driven high");
    a_oe_hold: assert property (p_oe_hold) else $error("data moved while clock high");
    a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    a_idle_stable: assert property (p_idle_stable) else $error("change on idle bus");
    a_cfg_by_ptr: assert property (p_cfg_by_ptr) else $error("cfg written elsewhere");
    a_hold_ptr: assert property (p_hold_ptr) else $error("hold without ext read");
    a_hold_bound: assert property (p_hold_bound) else $error("hold never released");
endmodule : smbus_temp_properties

/* testbench/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
    // Clock and wire level
    input  wire logic i_clk,
    input  wire logic i_sda,
    // Driven lines, released high
    output logic      o_scl,
    output logic      o_sda
);
    logic [6:0] addr = smbus_temp_pkg::SLAVE_ADDR;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic hp();
        repeat (4) @(posedge i_clk);
    endtask : hp
    task automatic bit_io(input logic b, output logic r);
        o_sda <= b;
        hp();
        o_scl <= 1'b1;
        hp();
        r = i_sda;
        o_scl <= 1'b0;
        @(posedge i_clk);
    endtask : bit_io
    task automatic start();
        o_sda <= 1'b1;
        hp();
        o_scl <= 1'b1;
        hp();
        o_sda <= 1'b0;
        hp();
        o_scl <= 1'b0;
        @(posedge i_clk);
    endtask : start
    task automatic tx(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ok = ok & ~r;
    endtask : tx
    // Kinds: 0 write byte, 1 read byte, 2 send byte, 3 receive byte
    // Single master here, so the pointer only moves by our own calls
    task automatic xfer(input int k, input logic [7:0] c, input logic [7:0] w,
                        output logic [7:0] d, output logic ok);
        logic r;
        ok = 1'b1;
        d = 8'h00;
        start();
        if (k != 3) begin
            tx({addr, 1'b0}, ok);
            tx(c, ok);
        end
        if (k == 0) tx(w, ok);
        if (k[0]) begin
            if (k == 1) start();
            tx({addr, 1'b1}, ok);
            for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
            bit_io(1'b1, r);
        end
        o_sda <= 1'b0;
        hp();
        o_scl <= 1'b1;
        hp();
        o_sda <= 1'b1;
        hp();
    endtask : xfer
endmodule : smbus_host_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int HC = 2000;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        scl;
    logic        sda_h;
    logic        oe;
    logic        hold;
    logic [59:0] raw = '0;
    logic [4:0]  vld = '0;
    logic [3:0]  dopen = '0;
    logic [3:0]  dshort = '0;
    logic [7:0]  cfg, ptr, rd, w, ext_m;
    logic [7:0]  expm [5];
    logic [7:0]  amap [5] = '{smbus_temp_pkg::ADDR_REMOTE1, smbus_temp_pkg::ADDR_REMOTE2,
        smbus_temp_pkg::ADDR_REMOTE3, smbus_temp_pkg::ADDR_REMOTE4, smbus_temp_pkg::ADDR_LOCAL};
    int          ev [6] = '{-8, 0, 200, 1023, 1024, 0};
    logic        ok;
    bit          hold_m = 1'b0;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          seed = 85;
    wire logic   sda_w = sda_h & ~oe;
    always #4 clk = ~clk;
    smbus_temp_regs #(.HOLD_CYCLES(HC)) uut (
        .I_SYS_CLK(clk), .I_SRST(srst), .I_SMB_CLK(scl), .I_SMB_DATA(sda_w),
        .O_SMB_DATA(), .O_SMB_DATA_OE(oe), .I_RAW_TEMP(raw), .I_RESULT_VALID(vld),
        .I_DIODE_ANODE_OPEN(dopen), .I_DIODE_SHORT(dshort), .O_CFG1(cfg),
        .O_HOLD_ACTIVE(hold), .O_POINTER(ptr));
    smbus_host_model host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fm(input int v, input bit f);
        if (f) return 8'hFF;
        if (v < 0) return 8'h00;
        if (v > 1023) return 8'h7F;
        return 8'(v / 8);
    endfunction : fm
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic load(input int c, input int v);
        bit f;
        @(posedge clk);
        f = (c < 4) && (dopen[c] || dshort[c]);
        raw[c*12 +: 12] <= v[11:0];
        vld[c] <= 1'b1;
        @(posedge clk);
        vld <= '0;
        if (!(c == 0 && hold_m)) expm[c] = fm(v, f);
        if (c == 0 && !hold_m) ext_m = (f || v < 0) ? 8'h00 : (v > 1023) ? 8'hE0 : 8'(v % 8 * 32);
    endtask : load
    task automatic rdreg(input logic [7:0] a);
        host.xfer(1, a, 8'h00, rd, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : rdreg
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(ptr, 8'h00);
        for (int c = 0; c < 5; c++) begin
            for (int i = 0; i < 6; i++) begin
                load(c, (i == 5) ? $random(seed) % 1200 : ev[i]);
                rdreg(amap[c]);
                chk(rd, expm[c]);
            end
        end
        $display("test results done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            dopen <= k[0] ? 4'h0 : 4'(1 << (k / 2));
            dshort <= k[0] ? 4'(1 << (k / 2)) : 4'h0;
            load(k / 2, 200);
            rdreg(amap[k / 2]);
            chk(rd, 8'hFF);
        end
        dopen <= 4'h0;
        dshort <= 4'h0;
        $display("test faults done");
        load(2, $random(seed) % 1000);
        host.xfer(2, amap[2], 8'h00, rd, ok);
        chk(ptr, amap[2]);
        host.xfer(3, 8'h00, 8'h00, rd, ok);
        chk(rd, expm[2]);
        w = 8'($random(seed));
        host.xfer(0, smbus_temp_pkg::ADDR_CFG1, w, rd, ok);
        chk({7'h00, ok}, 8'h01);
        chk(cfg, w);
        host.xfer(0, amap[1], ~w, rd, ok);
        rdreg(amap[1]);
        chk(rd, expm[1]);
        host.addr = smbus_temp_pkg::SLAVE_ADDR ^ 7'h01;
        host.xfer(2, 8'h03, 8'h00, rd, ok);
        chk({7'h00, ok}, 8'h00);
        chk(ptr, amap[1]);
        host.addr = smbus_temp_pkg::SLAVE_ADDR;
        $display("test protocols done");
        load(0, 1005);
        rdreg(smbus_temp_pkg::ADDR_EXT1);
        chk(rd, ext_m);
        chk({7'h00, hold}, 8'h01);
        hold_m = 1'b1;
        load(0, 80);
        rdreg(amap[0]);
        chk(rd, expm[0]);
        chk({7'h00, hold}, 8'h00);
        hold_m = 1'b0;
        load(0, 80);
        rdreg(amap[0]);
        chk(rd, expm[0]);
        rdreg(smbus_temp_pkg::ADDR_EXT1);
        repeat (HC - 200) @(posedge clk);
        chk({7'h00, hold}, 8'h01);
        repeat (205) @(posedge clk);
        chk({7'h00, hold}, 8'h00);
        load(0, 16);
        rdreg(amap[0]);
        chk(rd, expm[0]);
        $display("test hold done");
        summarize();
    end
endmodule : tb_top
bind smbus_temp_regs smbus_temp_properties #(.HOLD_CYCLES(HOLD_CYCLES)) props (
    .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_SMB_CLK(I_SMB_CLK),
    .I_SMB_DATA(I_SMB_DATA), .O_SMB_DATA(O_SMB_DATA), .O_SMB_DATA_OE(O_SMB_DATA_OE),
    .O_CFG1(O_CFG1), .O_HOLD_ACTIVE(O_HOLD_ACTIVE), .O_POINTER(O_POINTER));
